// ---- design/cod_defines.vh ----
/*
 Constants for the clock output divider channel: register offsets, field
 positions, reset values, encodings and timing counts.
 Assumes an Avalon-MM slave with 32-bit data and byte addresses.
*/
`ifndef COD_DEFINES_VH
`define COD_DEFINES_VH

// register byte offsets
`define COD_REG_CTRL 4'h0
`define COD_REG_DIV_LSB 4'h4
`define COD_REG_DIV_MSB 4'h8
`define COD_REG_DELAY 4'hc
`define COD_REG_STATUS 4'h0
`define COD_ADDR_W 4

// ctrl field positions
`define COD_CTRL_EN 0
`define COD_CTRL_SLIP_EN 1
`define COD_CTRL_SYNC_EN 2
`define COD_CTRL_MSLIP_EN 3
`define COD_CTRL_HIPERF 4
`define COD_CTRL_DYN_DRV 5
`define COD_CTRL_MODE_LO 6
`define COD_CTRL_MUX_LO 8
`define COD_CTRL_MUTE_LO 10
`define COD_CTRL_PAIR_LO 12
`define COD_CTRL_W 14
`define COD_CTRL_RST 14'h0000

// delay word fields
`define COD_DLY_COARSE_LO 0
`define COD_DLY_FINE_LO 8

// encodings
`define COD_MODE_NORMAL 2'b00
`define COD_MODE_PULSE 2'b11
`define COD_MUX_DIV 2'b00
`define COD_MUX_ANALOG 2'b01
`define COD_MUX_PAIR 2'b10
`define COD_MUX_VCO 2'b11
`define COD_MUTE_LOW 2'b10
`define COD_DIV_RST 12'h000
`define COD_COARSE_MAX 6'h23

// answer latency of the bus slave in cycles
`define COD_BUS_WAIT 1

`endif

// ---- design/cod_channel.v ----
/*
 One clock output divider channel: divider, half-cycle phase delay, source
 mux, slip and sync handling, pulse generator start-up and buffer gating.
 Assumes mclk_i is the vco clock and that broadcast event inputs are pulses
 from logic on the same clock; the pair channel and analog delayed clock
 arrive as same-clock levels and are used as data.
*/
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "cod_defines.vh"

module cod_channel #(
  parameter DIV_W = 12,
  parameter MSLIP_W = 12,
  parameter [MSLIP_W-1:0] MSLIP_CNT = 12'h001
) (
  input wire mclk_i,
  input wire rst_n_i,
  // avalon-mm slave
  input wire [`COD_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // chip-wide controls and broadcast events
  input wire sleep_i,
  input wire [6:0] pair_output_enables_i,
  input wire slip_req_i,
  input wire sync_req_i,
  input wire pulse_start_i,
  input wire pulse_stop_i,
  input wire pair_clk_i,
  input wire analog_clk_i,
  // channel outputs
  output wire clk_out_o,
  output wire buf_en_o,
  output wire clamp_low_o,
  output wire div_run_o
);

  // configuration registers
  reg [`COD_CTRL_W-1:0] ctrl_ff;
  reg [7:0] div_lsb_ff;
  reg [3:0] div_msb_ff;
  reg [4:0] coarse_ff;
  reg [4:0] fine_ff;
  reg wait_ff;
  reg [31:0] rdata_ff;

  wire ch_en = ctrl_ff[`COD_CTRL_EN];
  wire slip_en = ctrl_ff[`COD_CTRL_SLIP_EN];
  wire sync_en = ctrl_ff[`COD_CTRL_SYNC_EN];
  wire mslip_en = ctrl_ff[`COD_CTRL_MSLIP_EN];
  wire dyn_drv = ctrl_ff[`COD_CTRL_DYN_DRV];
  wire [1:0] mode = ctrl_ff[`COD_CTRL_MODE_LO +: 2];
  wire [1:0] mux_sel = ctrl_ff[`COD_CTRL_MUX_LO +: 2];
  wire [1:0] mute = ctrl_ff[`COD_CTRL_MUTE_LO +: 2];
  wire [2:0] pair_idx = ctrl_ff[`COD_CTRL_PAIR_LO +: 2] == 2'b11 ? 3'h6 : {1'b0, ctrl_ff[`COD_CTRL_PAIR_LO +: 2]};
  wire [DIV_W-1:0] ratio = {div_msb_ff, div_lsb_ff};

  wire bus_req = avs_read_i | avs_write_i;
  wire bus_take = bus_req & ~wait_ff;
  wire wr_take = bus_take & avs_write_i;
  // read data is fetched in the wait cycle so it stands at the accepting edge
  wire rd_load = avs_read_i & wait_ff;

  // state observed by software
  reg running_ff;
  reg pulse_act_ff;
  reg [MSLIP_W-1:0] slip_left_ff;

  // slave: one wait cycle, then the request is taken
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= bus_take ? 1'b1 : ~bus_req;
    end
  end

  // register writes with byte enables; lanes without enable keep their value
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= `COD_CTRL_RST;
      div_lsb_ff <= 8'h00;
      div_msb_ff <= 4'h0;
      coarse_ff <= 5'h00;
      fine_ff <= 5'h00;
    end else if (wr_take) begin
      case (avs_address_i)
        `COD_REG_CTRL: begin
          if (avs_byteenable_i[0]) begin
            ctrl_ff[7:0] <= avs_writedata_i[7:0];
          end
          if (avs_byteenable_i[1]) begin
            ctrl_ff[13:8] <= avs_writedata_i[13:8];
          end
        end
        `COD_REG_DIV_LSB: begin
          if (avs_byteenable_i[0]) begin
            div_lsb_ff <= avs_writedata_i[7:0];
          end
        end
        `COD_REG_DIV_MSB: begin
          if (avs_byteenable_i[0]) begin
            div_msb_ff <= avs_writedata_i[3:0];
          end
        end
        `COD_REG_DELAY: begin
          if (avs_byteenable_i[0]) begin
            coarse_ff <= avs_writedata_i[4:0];
          end
          if (avs_byteenable_i[1]) begin
            fine_ff <= avs_writedata_i[12:8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  // status bits are one cycle old at the accepting edge, fine for polling
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_load) begin
      case (avs_address_i)
        `COD_REG_CTRL: begin
          rdata_ff <= {running_ff, pulse_act_ff, 2'b00, slip_left_ff, 2'b00, ctrl_ff};
        end
        `COD_REG_DIV_LSB: begin
          rdata_ff <= {24'h000000, div_lsb_ff};
        end
        `COD_REG_DIV_MSB: begin
          rdata_ff <= {28'h0000000, div_msb_ff};
        end
        `COD_REG_DELAY: begin
          rdata_ff <= {19'h00000, fine_ff, 3'h0, coarse_ff};
        end
        default: begin
          rdata_ff <= 32'h0000_0000;
        end
      endcase
    end
  end

  // run permission; pulse mode runs only inside a chain
  wire permit = ch_en & pair_output_enables_i[pair_idx] & ~sleep_i;
  wire pulse_mode = (mode == `COD_MODE_PULSE);
  wire run = permit & (~pulse_mode | pulse_act_ff);

  // pulse chain state machine: power up on start, down after stop
  // leaving pulse mode or losing permission also ends the chain
  localparam [0:0] PG_IDLE = 1'b0;
  localparam [0:0] PG_CHAIN = 1'b1;
  reg nxt_pulse_act;
  always @* begin
    nxt_pulse_act = pulse_act_ff;
    case (pulse_act_ff)
      PG_IDLE: begin
        if (pulse_start_i && pulse_mode && permit) begin
          nxt_pulse_act = PG_CHAIN;
        end
      end
      PG_CHAIN: begin
        if (pulse_stop_i || !pulse_mode || !permit) begin
          nxt_pulse_act = PG_IDLE;
        end
      end
      default: begin
        nxt_pulse_act = PG_IDLE;
      end
    endcase
  end

  // chain state register
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_act_ff <= PG_IDLE;
    end else begin
      pulse_act_ff <= nxt_pulse_act;
    end
  end

  // rephase events: sync if enabled, pulse start in pulse mode
  wire rephase = (sync_req_i & sync_en) | (pulse_start_i & pulse_mode & permit);
  wire auto_slip = mslip_en & slip_en & (sync_req_i | pulse_start_i);

  // slip engine: each slip swallows one vco cycle of the divider
  // a new request restarts the count rather than adding to it
  reg [MSLIP_W-1:0] nxt_slip_left;
  wire [MSLIP_W-1:0] slip_one = {{(MSLIP_W-1){1'b0}}, 1'b1};
  wire slip_go = auto_slip | (slip_req_i & slip_en);
  always @* begin
    nxt_slip_left = slip_left_ff;
    if (slip_go) begin
      nxt_slip_left = mslip_en ? MSLIP_CNT : slip_one;
    end else if (slip_left_ff != {MSLIP_W{1'b0}}) begin
      nxt_slip_left = slip_left_ff - slip_one;
    end
  end

  // slip count register
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slip_left_ff <= {MSLIP_W{1'b0}};
    end else begin
      slip_left_ff <= nxt_slip_left;
    end
  end
  wire slip_hold = (slip_left_ff != {MSLIP_W{1'b0}});

  // divider: counts ratio vco cycles per output period (two for ratio 1), ~50% duty
  reg [DIV_W-1:0] cnt_ff;
  reg div_q_ff;
  reg [DIV_W-1:0] nxt_cnt;
  reg nxt_div_q;
  wire [DIV_W-1:0] one = {{(DIV_W-1){1'b0}}, 1'b1};
  wire [DIV_W-1:0] last = ratio - one;
  wire [DIV_W-1:0] half = {1'b0, ratio[DIV_W-1:1]};
  wire wrap = (cnt_ff >= last);
  // a rephase restarts the count; a slip freezes it for one cycle
  // ratio 0 wraps at all ones; the mux does not bypass it, so the divider path still outputs it
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_div_q = div_q_ff;
    if (!run || rephase) begin
      nxt_cnt = `COD_DIV_RST;
      nxt_div_q = 1'b0;
    end else if (!slip_hold) begin
      if (wrap) begin
        nxt_cnt = `COD_DIV_RST;
      end else begin
        nxt_cnt = cnt_ff + one;
      end
      if (ratio == one) begin
        nxt_div_q = ~div_q_ff;
      end else begin
        nxt_div_q = wrap | (cnt_ff + one < half);
      end
    end
  end

  // divider registers
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= `COD_DIV_RST;
      div_q_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      div_q_ff <= nxt_div_q;
    end
  end

  // coarse delay: whole-cycle shift line plus half-cycle pick
  // five bits reach 31 half steps, inside the 35-step ceiling, so no clip
  wire [4:0] coarse = coarse_ff;
  reg [17:0] dly_line_ff;
  reg half_ff;
  wire [17:0] tap_vec = {dly_line_ff[16:0], div_q_ff};
  // one flop per whole vco cycle of shift
  genvar gi;
  generate
    for (gi = 0; gi < 18; gi = gi + 1) begin : g_dly
      always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          dly_line_ff[gi] <= 1'b0;
        end else begin
          dly_line_ff[gi] <= tap_vec[gi];
        end
      end
    end
  endgenerate
  wire whole_tap = tap_vec[coarse[4:1]];
  // odd step is launched on the falling vco edge
  always @(negedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half_ff <= 1'b0;
    end else begin
      half_ff <= whole_tap;
    end
  end
  wire dly_out = coarse[0] ? half_ff : whole_tap;

  // source mux; vco selection reproduced as toggling data
  reg vco_tog_ff;
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vco_tog_ff <= 1'b0;
    end else begin
      vco_tog_ff <= ~vco_tog_ff;
    end
  end
  reg mux_out;
  // the vco itself cannot pass as data, so a toggle stands in for it
  always @* begin
    case (mux_sel)
      `COD_MUX_DIV: begin
        mux_out = dly_out;
      end
      `COD_MUX_ANALOG: begin
        mux_out = analog_clk_i;
      end
      `COD_MUX_PAIR: begin
        mux_out = pair_clk_i;
      end
      `COD_MUX_VCO: begin
        mux_out = vco_tog_ff;
      end
      default: begin
        mux_out = 1'b0;
      end
    endcase
  end

  // buffer enable and idle clamp
  wire buf_en = (pulse_mode & dyn_drv) ? run : ch_en;
  wire idle = ~run;
  wire clamp = buf_en & ch_en & idle & (mute == `COD_MUTE_LOW);
  reg clk_out_ff;
  reg buf_en_ff;
  reg clamp_ff;
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_out_ff <= 1'b0;
      buf_en_ff <= 1'b0;
      clamp_ff <= 1'b0;
      running_ff <= 1'b0;
    end else begin
      clk_out_ff <= (clamp | ~buf_en | idle) ? 1'b0 : mux_out;
      buf_en_ff <= buf_en;
      clamp_ff <= clamp;
      running_ff <= run;
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign clk_out_o = clk_out_ff;
  assign buf_en_o = buf_en_ff;
  assign clamp_low_o = clamp_ff;
  assign div_run_o = running_ff;

endmodule // cod_channel
`default_nettype wire

// ---- dv/cod_clk_receiver.sv ----
/*
 Receiving device model: measures the output clock period in mclk cycles.
 Assumes the output clock is a same-clock level.
*/
`timescale 1ns/10ps
`default_nettype none
module cod_clk_receiver (
  input wire logic mclk_i,
  input wire logic clk_i,
  input wire logic buf_en_i,
  output logic [15:0] per_o = 16'h0000,
  output logic vld_o = 1'b0
);
  logic q_ff = 1'b0;
  logic [15:0] cnt_ff = 16'h0000;
  // period counted rise to rise; buffer off means nothing arrives
  always @(posedge mclk_i) begin
    q_ff <= clk_i;
    vld_o <= 1'b0;
    cnt_ff <= cnt_ff + 16'h0001;
    if (clk_i && !q_ff && buf_en_i) begin
      per_o <= cnt_ff;
      cnt_ff <= 16'h0001;
      vld_o <= 1'b1;
    end
  end
endmodule // cod_clk_receiver
`default_nettype wire

// ---- dv/cod_channel_monitor.sv ----
/*
 Checker for the channel ports; shadows the ctrl word from bus writes.
 Assumes the master writes all byte lanes of ctrl.
*/
`timescale 1ns/10ps
`default_nettype none
module cod_channel_monitor (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic avs_read_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  input wire logic sleep_i,
  input wire logic [6:0] pair_output_enables_i,
  input wire logic pulse_start_i,
  input wire logic pulse_stop_i,
  input wire logic clk_out_o,
  input wire logic buf_en_o,
  input wire logic clamp_low_o,
  input wire logic div_run_o
);
  logic [13:0] ctl_ff;
  // shadow copy taken at the accepting edge only
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) ctl_ff <= 14'h0000;
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0) ctl_ff <= avs_writedata_i[13:0];
  end
  wire en = ctl_ff[0];
  wire dyn = ctl_ff[5];
  wire pls = ctl_ff[7:6] == 2'b11;
  wire [2:0] pidx = (ctl_ff[13:12] == 2'b11) ? 3'h6 : {1'b0, ctl_ff[13:12]};
  wire ok = en && !sleep_i && pair_output_enables_i[pidx];
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_start; ok && pls && pulse_start_i; endsequence
  sequence s_stop; pls && pulse_stop_i; endsequence
  property p_off; (!en)[*3] |-> !div_run_o && !buf_en_o; endproperty
  a_off: assert property (p_off) else $error("disabled channel active");
  property p_sleep; (en && sleep_i)[*3] |-> !div_run_o; endproperty
  a_sleep: assert property (p_sleep) else $error("runs in sleep");
  property p_buf; (en && !dyn && !sleep_i)[*3] |-> buf_en_o; endproperty
  a_buf: assert property (p_buf) else $error("buffer not on enable");
  property p_dyn; (pls && dyn && $stable(div_run_o))[*3] |-> buf_en_o == div_run_o; endproperty
  a_dyn: assert property (p_dyn) else $error("buffer not with divider");
  property p_clamp; (en && ctl_ff[11:10] == 2'b10 && buf_en_o && !div_run_o)[*2] |-> clamp_low_o && !clk_out_o; endproperty
  a_clamp: assert property (p_clamp) else $error("idle output not clamped");
  property p_float; (ctl_ff[11:10] == 2'b00 && !div_run_o)[*2] |-> !clamp_low_o; endproperty
  a_float: assert property (p_float) else $error("clamped with float setting");
  property p_start; s_start |-> ##[1:4] div_run_o; endproperty
  a_start: assert property (p_start) else $error("chain start no power up");
  property p_stop; s_stop |-> ##[1:4] !div_run_o; endproperty
  a_stop: assert property (p_stop) else $error("chain end no power down");
  property p_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_wait: assert property (p_wait) else $error("request not accepted in one cycle");
  property p_wone; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_wone: assert property (p_wone) else $error("waitrequest low too long");
endmodule // cod_channel_monitor
bind cod_channel cod_channel_monitor u_mon (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_write_i(avs_write_i), .avs_read_i(avs_read_i), .avs_writedata_i(avs_writedata_i),
  .avs_waitrequest_o(avs_waitrequest_o), .sleep_i(sleep_i), .pair_output_enables_i(pair_output_enables_i),
  .pulse_start_i(pulse_start_i), .pulse_stop_i(pulse_stop_i), .clk_out_o(clk_out_o), .buf_en_o(buf_en_o),
  .clamp_low_o(clamp_low_o), .div_run_o(div_run_o));
`default_nettype wire

// ---- dv/tb_clock_output_divider_channel.sv ----
/*
 Self-checking bench: bus tasks, divider period, mux paths, pulse mode.
 Assumes the receiver model sits on clk_out_o.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_clock_output_divider_channel;
  logic mclk_i = 0, rst_n_i = 0, rd = 0, wr = 0, slp = 0, ps = 0, pe = 0, slip = 0, pc = 0, ac = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [6:0] pen = 7'h01;
  wire [31:0] rdata;
  wire [15:0] per;
  wire wq, co, be, cl, dr, pv;
  int n_mismatch = 0, tests_run = 0, arm = 0, k = 0, n;
  logic [31:0] x = 26141, rd_q[$], per_q[$];
  cod_channel DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wq),
    .sleep_i(slp), .pair_output_enables_i(pen), .slip_req_i(slip), .sync_req_i(1'b0), .pulse_start_i(ps),
    .pulse_stop_i(pe), .pair_clk_i(pc), .analog_clk_i(ac), .clk_out_o(co), .buf_en_o(be), .clamp_low_o(cl),
    .div_run_o(dr));
  cod_clk_receiver u_rx (.mclk_i(mclk_i), .clk_i(co), .buf_en_i(be), .per_o(per), .vld_o(pv));
  initial forever #2 mclk_i = ~mclk_i;
  // pair clock period 6, analog clock period 10
  always @(posedge mclk_i) begin
    k <= k + 1;
    pc <= (k % 6) < 3;
    ac <= (k % 10) < 5;
  end
  function automatic logic [31:0] xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge mclk_i);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge mclk_i);
      t++;
    end while (wq !== 1'b0 && t < 50);
    if (t >= 50) n_mismatch++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(0, a, 32'h0);
  endtask
  task automatic meas(input int p, input int c);
    int t;
    t = 0;
    repeat (c) per_q.push_back(p);
    arm = c;
    while (arm > 0 && t < 3000) begin
      @(posedge mclk_i);
      t++;
    end
    if (arm > 0) n_mismatch++;
  endtask
  // one-cycle event: 0 slip, 1 chain start, 2 chain stop
  task automatic pulse(input int w);
    @(posedge mclk_i);
    if (w == 0) slip <= 1'b1;
    else if (w == 1) ps <= 1'b1;
    else pe <= 1'b1;
    @(posedge mclk_i);
    slip <= 1'b0;
    ps <= 1'b0;
    pe <= 1'b0;
  endtask
  // result watcher: oldest note against what appears
  always @(posedge mclk_i) begin
    if (rd && wq === 1'b0 && rd_q.size() > 0) check("readdata", rd_q.pop_front(), rdata);
    if (pv && arm > 0 && per_q.size() > 0) begin
      arm--;
      check("period", per_q.pop_front(), {16'h0, per});
    end
  end
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  initial begin
    logic [3:0] ad[3] = '{4'h4, 4'h8, 4'hc};
    logic [31:0] wv[3] = '{32'ha5, 32'ha, 32'h1f13};
    int mp[4] = '{0, 10, 6, 2};
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    check("waitrequest", 1, wq);
    check("div_run", 0, dr);
    for (int i = 0; i < 3; i++) begin
      bus(1, ad[i], wv[i]);
      rchk(ad[i], wv[i]);
    end
    rchk(4'h2, 32'h0);
    bus(1, 4'h8, 32'h0);
    bus(1, 4'h0, 32'h1);
    for (int i = 0; i < 3; i++) begin
      n = 2 + xs() % 15;
      bus(1, 4'h4, n);
      repeat (40) @(posedge mclk_i);
      if (i == 0) rchk(4'h0, 32'h80000001);
      bus(1, 4'h0, 32'h5);
      bus(1, 4'h0, 32'h1);
      pulse(0);
      meas(n, 2);
    end
    bus(1, 4'h4, 32'h0);
    for (int m = 1; m < 4; m++) begin
      bus(1, 4'h0, 32'h1 | (m << 8));
      repeat (30) @(posedge mclk_i);
      meas(mp[m], 2);
    end
    slp <= 1'b1;
    repeat (8) @(posedge mclk_i);
    check("div_run", 0, dr);
    slp <= 1'b0;
    bus(1, 4'h4, 32'd40);
    bus(1, 4'h0, 32'h8e1);
    repeat (8) @(posedge mclk_i);
    check("div_run", 0, dr);
    pulse(1);
    repeat (100) @(posedge mclk_i);
    meas(40, 1);
    check("buf_en", 1, be);
    pulse(2);
    repeat (8) @(posedge mclk_i);
    check("buf_en", 0, be);
    check("clamp_low", 0, cl);
    bus(1, 4'h0, 32'h8c1);
    repeat (8) @(posedge mclk_i);
    check("buf_en", 1, be);
    check("clamp_low", 1, cl);
    check("clk_out", 0, co);
    bus(1, 4'h0, 32'h0);
    repeat (8) @(posedge mclk_i);
    check("div_run", 0, dr);
    final_report();
  end
endmodule // tb_clock_output_divider_channel
`default_nettype wire
